// ==== pt3_port.sv ====
// Four-bit port with per-pin direction, pull-up and control-mode selection
`timescale 1ns/1ps
`include "pt3_consts.svh"
module pt3_port (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Configuration, written by software
	input wire pt3_pkg::pt3_bits_t cfg_dir,
	input wire pt3_pkg::pt3_bits_t cfg_pullup,
	input wire pt3_pkg::pt3_bits_t cfg_mode,
	input wire logic [7:0] cfg_edge_sel,
	input wire logic cfg_timer_out_sel,
	input wire logic cfg_load,
	// Port data
	input wire pt3_pkg::pt3_bits_t port_out_data,
	input wire logic port_out_load,
	output logic [3:0] port_in_data,
	// Pins
	input wire logic [3:0] pin_in,
	output logic [3:0] pin_out,
	output logic [3:0] pin_oe,
	output logic [3:0] pin_pullup_en,
	// Peripheral side
	output logic [3:0] ext_irq_pulse,
	output logic timer_count_clk_in,
	input wire logic timer_wave_out,
	// Status readback
	output logic [3:0] port_direction_reg,
	output logic [3:0] pullup_option_reg,
	output logic [3:0] port_mode_reg
);
	import pt3_pkg::*;
	pt3_bits_t dir_next;
	pt3_bits_t pu_next;
	pt3_bits_t mode_next;
	logic [7:0] edge_sel_reg;
	logic [7:0] edge_sel_next;
	logic tsel_reg;
	logic tsel_next;
	pt3_bits_t out_reg;
	pt3_bits_t out_next;
	logic [3:0] sync1_reg;
	logic [3:0] sync2_reg;
	logic [3:0] sync1_next;
	logic [3:0] sync2_next;
	logic [3:0] in_reg;
	logic [3:0] in_next;
	logic tclk_reg;
	logic tclk_next;
	logic [3:0] irq_gate;
	pt3_edge_if eif ();

	// ***********************************************
	// Helper decodes
	// ***********************************************
	// Pin 3 belongs to the timer while its mode bit is set
	function automatic logic timer_pin_owned(input pt3_bits_t mode_bits);
		timer_pin_owned = mode_bits[`PT3_TIMER_PIN];
	endfunction

	// Pin 3 carries the timer output only when software picked the output role
	function automatic logic timer_drives_pin(input pt3_bits_t mode_bits, input logic sel);
		timer_drives_pin = timer_pin_owned(mode_bits) & sel;
	endfunction

	// ***********************************************
	// Configuration registers
	// ***********************************************
	// Load all settings at once so a mode change never sees half a setup
	always_comb begin
		dir_next = port_direction_reg;
		pu_next = pullup_option_reg;
		mode_next = port_mode_reg;
		edge_sel_next = edge_sel_reg;
		tsel_next = tsel_reg;
		if (cfg_load) begin
			dir_next = cfg_dir;
			pu_next = cfg_pullup;
			mode_next = cfg_mode;
			edge_sel_next = cfg_edge_sel;
			tsel_next = cfg_timer_out_sel;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			port_direction_reg <= `PT3_DIR_RESET;
			pullup_option_reg <= `PT3_PU_RESET;
			port_mode_reg <= `PT3_MODE_RESET;
			edge_sel_reg <= `PT3_EDGE_SEL_RESET;
			tsel_reg <= `PT3_TSEL_RESET;
		end else begin
			port_direction_reg <= dir_next;
			pullup_option_reg <= pu_next;
			port_mode_reg <= mode_next;
			edge_sel_reg <= edge_sel_next;
			tsel_reg <= tsel_next;
		end
	end

	// ***********************************************
	// Output latch
	// ***********************************************
	// The latch loads on its own strobe so data writes never disturb the setup
	// It keeps its value while a pin is an input, ready for a later turn to output
	always_comb begin
		out_next = out_reg;
		if (port_out_load) begin
			out_next = port_out_data;
		end
	end

	// Latch register
	always_ff @(posedge clk) begin
		if (rst) begin
			out_reg <= `PT3_OUT_RESET;
		end else begin
			out_reg <= out_next;
		end
	end

	// ***********************************************
	// Pin input synchroniser
	// ***********************************************
	// Two flops before any logic looks at the pins
	// Costs two cycles of latency, but a pad that moves near the edge cannot
	// reach the edge detector or the timer as a metastable level
	always_comb begin
		sync1_next = pin_in;
		sync2_next = sync1_reg;
	end

	// Only the second stage is read by the logic below
	always_ff @(posedge clk) begin
		if (rst) begin
			sync1_reg <= `PT3_LEVEL_RESET;
			sync2_reg <= `PT3_LEVEL_RESET;
		end else begin
			sync1_reg <= sync1_next;
			sync2_reg <= sync2_next;
		end
	end

	// ***********************************************
	// Input data and timer clock
	// ***********************************************
	// Output pins read back their own latch, inputs read the pad
	always_comb begin
		for (int i = 0; i < `PT3_NPINS; i++) begin
			in_next[i] = port_direction_reg[i] ? sync2_reg[i] : out_reg[i];
		end
		// Count clock only while pin 3 is in control mode with its direction bit set, even while it drives the timer output
		// The count clock is a sampled level, so its pulses must last a few cycles
		tclk_next = timer_pin_owned(port_mode_reg) & port_direction_reg[`PT3_TIMER_PIN]
			& sync2_reg[`PT3_TIMER_PIN];
	end

	// Registered so the timer sees a clean level, not a mux glitch
	always_ff @(posedge clk) begin
		if (rst) begin
			in_reg <= `PT3_LEVEL_RESET;
			tclk_reg <= 1'b0;
		end else begin
			in_reg <= in_next;
			tclk_reg <= tclk_next;
		end
	end

	assign port_in_data = in_reg;
	assign timer_count_clk_in = tclk_reg;

	// ***********************************************
	// Interrupt edge detection
	// ***********************************************
	// Ports in plain mode feed a steady low to the detector
	// Limitation: entering control mode with the pad high reads as a rising edge,
	// so software should mask the first request after a mode change
	assign eif.level = sync2_reg & port_mode_reg;
	assign eif.edge_sel = edge_sel_reg;

	pt3_edge_det pt3_edge_det_i (
		.clk(clk),
		.rst(rst),
		.eif(eif)
	);

	// Pulse only while the pin is still in control mode
	// A pulse already in flight when the pin leaves control mode is dropped
	always_comb begin
		for (int i = 0; i < `PT3_NPINS; i++) begin
			irq_gate[i] = eif.irq_pulse[i] & port_mode_reg[i];
		end
	end
	assign ext_irq_pulse = irq_gate;

	// ***********************************************
	// Pin drive
	// ***********************************************
	// Timer output overrides the latch on pin 3 in control mode when the output role is selected
	always_comb begin
		pin_out = out_reg;
		pin_oe = ~port_direction_reg;
		if (timer_drives_pin(port_mode_reg, tsel_reg)) begin
			pin_out[`PT3_TIMER_PIN] = timer_wave_out;
			pin_oe[`PT3_TIMER_PIN] = 1'b1;
		end
	end

	// Pull-up only makes sense on an input pin
	// An output pin would fight its own resistor and waste supply current
	always_comb begin
		for (int i = 0; i < `PT3_NPINS; i++) begin
			pin_pullup_en[i] = pullup_option_reg[i] & port_direction_reg[i];
		end
	end
endmodule

// ==== pt3_consts.svh ====
// Constants for the four-bit port with control-mode pin functions
// How it works
// - Each of the four pins is an input or an output as its own direction bit says, except pin 3 while it drives the timer output.
// - Each pin has its own pull-up enable bit, driven out to the pad as a level while its direction bit makes it an input.
// - Each pin is switched between plain port use and control use by its own mode bit.
// - In control mode the pins carry external interrupt inputs and the timer input and output.
// - Each interrupt input detects rising, falling or both edges as software selects.
// - Pin 3 in control mode, while it is an input, feeds the timer count clock input.
// - Pin 3 in control mode can instead drive the timer output onto the pin.
`ifndef PT3_CONSTS_SVH
`define PT3_CONSTS_SVH
// ***********************************************
// Widths and reset values
// ***********************************************
`define PT3_NPINS 4
`define PT3_TIMER_PIN 3
`define PT3_DIR_RESET 4'hF
`define PT3_MODE_RESET 4'h0
`define PT3_PU_RESET 4'h0
`define PT3_OUT_RESET 4'h0
`define PT3_EDGE_SEL_RESET 8'h00
`define PT3_TSEL_RESET 1'b0
`define PT3_LEVEL_RESET 4'h0
// Edge select codes
`define PT3_EDGE_NONE 2'h0
`define PT3_EDGE_RISE 2'h1
`define PT3_EDGE_FALL 2'h2
`define PT3_EDGE_BOTH 2'h3
`endif

// ==== pt3_pkg.sv ====
// Types shared by the port block
package pt3_pkg;
	typedef logic [1:0] pt3_edge_t;
	typedef logic [3:0] pt3_bits_t;
endpackage

// ==== pt3_edge_if.sv ====
// Interface between the port top and its edge detector
`timescale 1ns/1ps
interface pt3_edge_if;
	logic [3:0] level;
	logic [7:0] edge_sel;
	logic [3:0] irq_pulse;
	modport top (output level, output edge_sel, input irq_pulse);
	modport det (input level, input edge_sel, output irq_pulse);
endinterface

// ==== pt3_edge_det.sv ====
// Per-pin valid-edge detector for the external interrupt inputs
`timescale 1ns/1ps
`include "pt3_consts.svh"
module pt3_edge_det (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Link to the top
	pt3_edge_if.det eif
);
	import pt3_pkg::*;
	logic [3:0] prev_reg;
	logic [3:0] prev_next;
	logic [3:0] pulse_reg;
	logic [3:0] pulse_next;

	// True when the selected edge kind matches this transition
	function automatic logic edge_hit(input pt3_edge_t sel, input logic old_v, input logic new_v);
		logic rise;
		logic fall;
		rise = ~old_v & new_v;
		fall = old_v & ~new_v;
		case (sel)
			`PT3_EDGE_RISE: edge_hit = rise;
			`PT3_EDGE_FALL: edge_hit = fall;
			`PT3_EDGE_BOTH: edge_hit = rise | fall;
			default: edge_hit = 1'b0;
		endcase
	endfunction

	// Next previous level and one-cycle pulses
	always_comb begin
		prev_next = eif.level;
		for (int i = 0; i < `PT3_NPINS; i++) begin
			pulse_next[i] = edge_hit(eif.edge_sel[2*i +: 2], prev_reg[i], eif.level[i]);
		end
	end

	// Register stage; level is already synchronised so no glitch pulses
	always_ff @(posedge clk) begin
		if (rst) begin
			prev_reg <= `PT3_LEVEL_RESET;
			pulse_reg <= `PT3_LEVEL_RESET;
		end else begin
			prev_reg <= prev_next;
			pulse_reg <= pulse_next;
		end
	end

	assign eif.irq_pulse = pulse_reg;
endmodule

// ==== pt3_pads.sv ====
// Pad model: external sources, loads and pull-ups on the four pins
`timescale 1ns/1ps
module pt3_pads (
	// Clock and both sides of the pads
	input wire logic clk,
	input wire logic [3:0] pin_out, pin_oe, pin_pullup_en, ext_drv, ext_en,
	output logic [3:0] pin_in
);
	logic flip = 1'b0;
	// A floating pad toggles, so a stale level can never pass for a read
	always @(posedge clk) flip <= ~flip;
	// Driver wins, then the outside source, then the pull-up
	always_comb for (int i = 0; i < 4; i++)
		pin_in[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_drv[i] : pin_pullup_en[i] | flip;
endmodule

// ==== pt3_port_monitor.sv ====
// Checker of the port block's pins, readback and pulses
`timescale 1ns/1ps
module pt3_port_monitor (
	// Watched ports
	input wire logic clk, rst, cfg_load, timer_wave_out, timer_count_clk_in,
	input wire logic [3:0] cfg_dir, cfg_mode, pin_in, pin_out, pin_oe, pin_pullup_en,
	input wire logic [3:0] ext_irq_pulse, port_direction_reg, pullup_option_reg, port_mode_reg
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// Direction, pull-up and mode readback
	AST_OE: assert property (port_mode_reg == 4'h0 |-> pin_oe == ~port_direction_reg)
		else $error("oe");
	AST_PU: assert property (pin_pullup_en == (pullup_option_reg & port_direction_reg))
		else $error("pullup");
	AST_LOAD: assert property (cfg_load |=> port_direction_reg == $past(cfg_dir)
		&& port_mode_reg == $past(cfg_mode)) else $error("load");
	AST_RST: assert property (disable iff (1'b0) rst |=> port_direction_reg == 4'hF
		&& port_mode_reg == 4'h0 && pullup_option_reg == 4'h0) else $error("reset");
	// Pulses last one cycle and only in control mode
	AST_PULSE: assert property (|ext_irq_pulse |=> (ext_irq_pulse & $past(ext_irq_pulse)) == 4'h0)
		else $error("pulse");
	AST_GATE: assert property ((ext_irq_pulse & ~port_mode_reg & ~$past(port_mode_reg)) == 4'h0)
		else $error("gate");
	// Timer pin: driven output or three-edge delayed clock input
	AST_TOUT: assert property (port_mode_reg[3] && port_direction_reg[3] && pin_oe[3]
		|-> pin_out[3] == timer_wave_out) else $error("tout");
	AST_TCLK: assert property ((port_mode_reg[3] && port_direction_reg[3] && !pin_oe[3]) [*4]
		|-> timer_count_clk_in == $past(pin_in[3], 3)) else $error("tclk");
	cover property (|ext_irq_pulse);
	cover property (cfg_load ##1 port_mode_reg[3]);
	cover property (pin_oe[3] && port_mode_reg[3]);
endmodule
bind pt3_port pt3_port_monitor pt3_port_monitor_i (.*);

// ==== pt3_port_tb.sv ====
// Self-checking bench for the four-bit port block
`timescale 1ns/1ps
module pt3_port_tb;
	logic clk = 1'b0, rst = 1'b1, ld = 1'b0, tsel = 1'b0, oload = 1'b0, tw = 1'b0, tclk;
	logic [3:0] dir = 4'hF, pu = 4'h0, mode = 4'h0, od = 4'h0, drv = 4'h0, den = 4'hF, seen;
	logic [3:0] pin_in, pout, poe, ppu, irq, pind, dirr, pur, moder;
	logic [7:0] es = 8'h00;
	int bad_count = 0, checks_done = 0, cyc = 0;
	always #20 clk = ~clk;
	pt3_port pt3_port_i (.clk(clk), .rst(rst), .cfg_dir(dir), .cfg_pullup(pu), .cfg_mode(mode),
		.cfg_edge_sel(es), .cfg_timer_out_sel(tsel), .cfg_load(ld), .port_out_data(od),
		.port_out_load(oload), .port_in_data(pind), .pin_in(pin_in), .pin_out(pout),
		.pin_oe(poe), .pin_pullup_en(ppu), .ext_irq_pulse(irq), .timer_count_clk_in(tclk),
		.timer_wave_out(tw), .port_direction_reg(dirr), .pullup_option_reg(pur),
		.port_mode_reg(moder));
	pt3_pads pt3_pads_i (.clk(clk), .pin_out(pout), .pin_oe(poe), .pin_pullup_en(ppu),
		.ext_drv(drv), .ext_en(den), .pin_in(pin_in));
	task automatic chk(input logic [3:0] g, input logic [3:0] e);
		checks_done++;
		if (g !== e) begin
			bad_count++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	// Loads every setting in one cycle, inputs move at the falling edge
	task automatic cfg(input logic [3:0] d, p, m, input logic [7:0] s, input logic t);
		@(negedge clk) {dir, pu, mode, es, tsel, ld} = {d, p, m, s, t, 1'b1};
		@(negedge clk) ld = 1'b0;
	endtask
	// Drives the pads and gathers every pulse over the sync latency
	task automatic pads(input logic [3:0] v);
		@(negedge clk) {drv, seen} = {v, 4'h0};
		repeat (6) @(negedge clk) seen = seen | irq;
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// Cuts a hang short well past the expected run
	always @(posedge clk) if (++cyc == 3000) begin
		bad_count++;
		conclude();
	end
	initial begin
		repeat (10) @(negedge clk);
		rst = 1'b0;
		chk(dirr, 4'hF);
		chk(pur | moder | poe, 4'h0);
		cfg(4'h5, 4'hF, 4'h0, 8'h00, 1'b0);
		chk(poe, 4'hA);
		chk(ppu, 4'h5);
		{den, drv} = 8'h11;
		@(negedge clk) {od, oload} = {4'hA, 1'b1};
		@(negedge clk) oload = 1'b0;
		chk(pout & poe, 4'hA);
		repeat (4) @(negedge clk);
		chk(pind, 4'hF);
		$display("port test done");
		{den, drv} = 8'hF0;
		for (int k = 0; k < 4; k++) begin
			cfg(4'hF, 4'h0, 4'hF, {4{k[1:0]}}, 1'b0);
			pads(4'hF);
			chk(seen, {4{k[0]}});
			chk({3'h0, tclk}, 4'h1);
			pads(4'h0);
			chk(seen, {4{k[1]}});
		end
		cfg(4'hF, 4'h0, 4'h0, 8'hFF, 1'b0);
		pads(4'hF);
		chk(seen, 4'h0);
		cfg(4'hF, 4'h0, 4'h1, 8'hFF, 1'b0);
		pads(4'h0);
		chk(seen, 4'h1);
		$display("edge test done");
		den = 4'h7;
		cfg(4'hF, 4'h0, 4'h8, 8'h00, 1'b1);
		@(negedge clk) tw = 1'b1;
		#1 chk({poe[3], pout[3], pin_in[3], 1'b0}, 4'hE);
		@(negedge clk) tw = 1'b0;
		#1 chk({poe[3], pout[3], 2'h0}, 4'h8);
		@(negedge clk) rst = 1'b1;
		repeat (2) @(negedge clk);
		rst = 1'b0;
		chk(poe | moder, 4'h0);
		$display("timer and reset test done");
		conclude();
	end
endmodule
